// ---- design/fsle_encoder.sv ----
`timescale 1ns/1ns
// Behaviour
// - The Ethernet PHY is held at 100 Mbit/s full duplex with automatic polarity and crossover sensing.
// - IO-device network LED is off without controller, green with controller running, flashing when stopped.
// - IO-device module LED is off unpowered, in setup or network init, and steady red in exception.
// - IO-device module LED gives 1, 2, 3 or 4 red flashes for ident mismatch, no IP, no name, major error.
// - IO-device module LED is green in normal use and flashes green on diagnostics or identify request.
// - IO-device link LED is off without link, green with link, flashing green with traffic.
// - EtherNet/IP network LED is off, green, flashing green, red or flashing red per IP and connection state.
// - EtherNet/IP module LED is green under a running scanner, flashing green idle, red or flashing red on faults.
// - EtherNet/IP link LED is off without link, green with link, flashing green on activity.
// - DeviceNet network LED shows off, green, 1 Hz flash, red, 1 Hz red flash or alternating in self test.
// - DeviceNet module LED shows off, green, 1 Hz flash, red, 1 Hz red flash or alternating in self test.
// - PROFIBUS operation LED is off, green, flashing green, or one or two red flashes for errors.
// - PROFIBUS status LED is off, green, flashing green on diagnostics, and red in exception.
module fsle_encoder
  import fsle_pkg::*;
#(
  parameter int TICK_CYCLES = FSLE_TICK_CYCLES
)
(
  input  wire logic     core_clk,
  input  wire logic     rst,
  input  fsle_variant_e variant,
  input  fsle_status_s  status,
  output fsle_led_s     network_indicator,
  output fsle_led_s     module_indicator,
  output fsle_led_s     link_indicator,
  output fsle_phy_s     phy_cfg
);

  function automatic fsle_pat_s mk(input fsle_pat_e pat, input logic [2:0] count);
    fsle_pat_s p;
    p.pat   = pat;
    p.count = count;
    return p;
  endfunction

  function automatic fsle_pat_s steady(input fsle_pat_e pat);
    return mk(pat, FSLE_CNT_NONE);
  endfunction

  function automatic fsle_pat_s iodev_net(input fsle_status_s s);
    if (!s.powered || !s.ctrl_connected)
      return steady(FSLE_PAT_OFF);
    else if (s.ctrl_run)
      return steady(FSLE_PAT_GREEN);
    else
      return steady(FSLE_PAT_FLASH_GREEN);
  endfunction

  function automatic fsle_pat_s iodev_mod(input fsle_status_s s);
    if (!s.powered || s.setup_state || s.network_init_state)
      return steady(FSLE_PAT_OFF);
    else if (s.exception)
      return steady(FSLE_PAT_RED);
    else if (s.major_internal)
      return mk(FSLE_PAT_COUNT_RED, FSLE_CNT_MAJOR);
    else if (s.ident_mismatch)
      return mk(FSLE_PAT_COUNT_RED, FSLE_CNT_IDENT);
    else if (!s.ip_set)
      return mk(FSLE_PAT_COUNT_RED, FSLE_CNT_NO_IP);
    else if (!s.station_name_set)
      return mk(FSLE_PAT_COUNT_RED, FSLE_CNT_NO_NAME);
    else if (s.diag_present || s.identify_req)
      return steady(FSLE_PAT_FLASH_GREEN);
    else
      return steady(FSLE_PAT_GREEN);
  endfunction

  function automatic fsle_pat_s eth_link(input fsle_status_s s);
    if (!s.powered || !s.link_up)
      return steady(FSLE_PAT_OFF);
    else if (s.link_activity)
      return steady(FSLE_PAT_FLASH_GREEN);
    else
      return steady(FSLE_PAT_GREEN);
  endfunction

  function automatic fsle_pat_s enip_net(input fsle_status_s s);
    if (!s.powered || !s.ip_set)
      return steady(FSLE_PAT_OFF);
    else if (s.dup_ip || s.fatal_error)
      return steady(FSLE_PAT_RED);
    else if (s.conn_timeout)
      return steady(FSLE_PAT_FLASH_RED);
    else if (s.conn_established)
      return steady(FSLE_PAT_GREEN);
    else if (s.online)
      return steady(FSLE_PAT_FLASH_GREEN);
    else
      return steady(FSLE_PAT_OFF);
  endfunction

  function automatic fsle_pat_s enip_mod(input fsle_status_s s);
    if (!s.powered)
      return steady(FSLE_PAT_OFF);
    else if (s.major_fault || s.exception || s.fatal_error)
      return steady(FSLE_PAT_RED);
    else if (s.recov_fault)
      return steady(FSLE_PAT_FLASH_RED);
    else if (!s.configured || s.scanner_idle)
      return steady(FSLE_PAT_FLASH_GREEN);
    else if (s.scanner_run)
      return steady(FSLE_PAT_GREEN);
    else
      return steady(FSLE_PAT_FLASH_GREEN);
  endfunction

  function automatic fsle_pat_s dnet_net(input fsle_status_s s);
    if (!s.powered)
      return steady(FSLE_PAT_OFF);
    else if (s.self_test)
      return steady(FSLE_PAT_ALT);
    else if (s.critical_link)
      return steady(FSLE_PAT_RED);
    else if (s.conn_timeout)
      return steady(FSLE_PAT_FLASH_RED);
    else if (!s.online)
      return steady(FSLE_PAT_OFF);
    else if (s.conn_established)
      return steady(FSLE_PAT_GREEN);
    else
      return steady(FSLE_PAT_FLASH_GREEN);
  endfunction

  function automatic fsle_pat_s dnet_mod(input fsle_status_s s);
    if (!s.powered)
      return steady(FSLE_PAT_OFF);
    else if (s.self_test)
      return steady(FSLE_PAT_ALT);
    else if (s.major_fault)
      return steady(FSLE_PAT_RED);
    else if (s.recov_fault)
      return steady(FSLE_PAT_FLASH_RED);
    else if (!s.initialised)
      return steady(FSLE_PAT_OFF);
    else if (!s.configured)
      return steady(FSLE_PAT_FLASH_GREEN);
    else
      return steady(FSLE_PAT_GREEN);
  endfunction

  function automatic fsle_pat_s pbus_op(input fsle_status_s s);
    if (!s.powered)
      return steady(FSLE_PAT_OFF);
    else if (s.param_error)
      return mk(FSLE_PAT_COUNT_RED, FSLE_CNT_PARAM);
    else if (s.config_error)
      return mk(FSLE_PAT_COUNT_RED, FSLE_CNT_CONFIG);
    else if (!s.online)
      return steady(FSLE_PAT_OFF);
    else if (s.data_exchange)
      return steady(FSLE_PAT_GREEN);
    else
      return steady(FSLE_PAT_FLASH_GREEN);
  endfunction

  function automatic fsle_pat_s pbus_st(input fsle_status_s s);
    if (!s.powered)
      return steady(FSLE_PAT_OFF);
    else if (s.exception)
      return steady(FSLE_PAT_RED);
    else if (!s.initialised)
      return steady(FSLE_PAT_OFF);
    else if (s.diag_present)
      return steady(FSLE_PAT_FLASH_GREEN);
    else
      return steady(FSLE_PAT_GREEN);
  endfunction

  // Per-variant decode; PROFIBUS operation and status use the network and module slots
  wire       is_iodev_w = (variant == FSLE_VAR_IODEV);
  wire       is_enip_w  = (variant == FSLE_VAR_ENIP);
  wire       is_dnet_w  = (variant == FSLE_VAR_DNET);

  wire fsle_pat_s net_pat_w  = is_iodev_w ? iodev_net(status) :
                               is_enip_w  ? enip_net(status)  :
                               is_dnet_w  ? dnet_net(status)  :
                                            pbus_op(status);
  wire fsle_pat_s mod_pat_w  = is_iodev_w ? iodev_mod(status) :
                               is_enip_w  ? enip_mod(status)  :
                               is_dnet_w  ? dnet_mod(status)  :
                                            pbus_st(status);
  wire fsle_pat_s link_pat_w = (is_iodev_w || is_enip_w) ? eth_link(status) : steady(FSLE_PAT_OFF);

  logic      tick_w;
  fsle_led_s net_led_w;
  fsle_led_s mod_led_w;
  fsle_led_s link_led_w;

  fsle_tick #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .core_clk (core_clk),
    .rst      (rst),
    .tick     (tick_w)
  );

  fsle_led_drv u_net_drv (
    .core_clk (core_clk),
    .rst      (rst),
    .tick     (tick_w),
    .pattern  (net_pat_w),
    .led      (net_led_w)
  );

  fsle_led_drv u_mod_drv (
    .core_clk (core_clk),
    .rst      (rst),
    .tick     (tick_w),
    .pattern  (mod_pat_w),
    .led      (mod_led_w)
  );

  fsle_led_drv u_link_drv (
    .core_clk (core_clk),
    .rst      (rst),
    .tick     (tick_w),
    .pattern  (link_pat_w),
    .led      (link_led_w)
  );

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      network_indicator <= '0;
      module_indicator  <= '0;
      link_indicator    <= '0;
      phy_cfg           <= '0;
    end
    else
    begin
      network_indicator <= net_led_w;
      module_indicator  <= mod_led_w;
      link_indicator    <= link_led_w;
      phy_cfg           <= {FSLE_PHY_SPEED_100M, FSLE_PHY_FULL_DUP, FSLE_PHY_AUTO_MDIX, FSLE_PHY_AUTO_POL};
    end
  end

  property p_phy_cfg;
    @(posedge core_clk) disable iff (rst)
    !$past(rst) |-> phy_cfg.speed_100m && phy_cfg.full_duplex && phy_cfg.auto_mdix && phy_cfg.auto_polarity;
  endproperty
  a_phy_cfg: assert property (p_phy_cfg) else $error("PHY not set to 100M full duplex auto");

  property p_iodev_net;
    @(posedge core_clk) disable iff (rst)
    is_iodev_w && status.powered && status.ctrl_connected && status.ctrl_run
      |=> network_indicator.green && !network_indicator.red;
  endproperty
  a_iodev_net: assert property (p_iodev_net) else $error("IO-device network LED not green in run");

  property p_iodev_exc;
    @(posedge core_clk) disable iff (rst)
    is_iodev_w && status.powered && !status.setup_state && !status.network_init_state && status.exception
      |=> module_indicator.red && !module_indicator.green;
  endproperty
  a_iodev_exc: assert property (p_iodev_exc) else $error("IO-device module LED not red in exception");

  property p_iodev_off;
    @(posedge core_clk) disable iff (rst)
    is_iodev_w && status.setup_state |=> !module_indicator.red && !module_indicator.green;
  endproperty
  a_iodev_off: assert property (p_iodev_off) else $error("IO-device module LED lit in setup");

  property p_iodev_count;
    @(posedge core_clk) disable iff (rst)
    is_iodev_w && status.powered && !status.setup_state && !status.network_init_state && !status.exception
      && !status.major_internal && !status.ident_mismatch && !status.ip_set
      |-> mod_pat_w.pat == FSLE_PAT_COUNT_RED && mod_pat_w.count == 3'h2;
  endproperty
  a_iodev_count: assert property (p_iodev_count) else $error("missing IP not two red flashes");

  property p_iodev_green;
    @(posedge core_clk) disable iff (rst)
    (mod_pat_w.pat == FSLE_PAT_FLASH_GREEN) |=> !module_indicator.red;
  endproperty
  a_iodev_green: assert property (p_iodev_green) else $error("module flash green shows red");

  property p_link_off;
    @(posedge core_clk) disable iff (rst)
    !status.link_up |=> !link_indicator.green && !link_indicator.red;
  endproperty
  a_link_off: assert property (p_link_off) else $error("link LED lit without link");

  property p_enip_dup;
    @(posedge core_clk) disable iff (rst)
    is_enip_w && status.powered && status.ip_set && status.dup_ip |=> network_indicator.red && !network_indicator.green;
  endproperty
  a_enip_dup: assert property (p_enip_dup) else $error("duplicate IP not steady red");

  property p_dnet_alt;
    @(posedge core_clk) disable iff (rst)
    is_dnet_w && status.powered && status.self_test [*2]
      |=> network_indicator.red != network_indicator.green;
  endproperty
  a_dnet_alt: assert property (p_dnet_alt) else $error("self test not alternating");

  property p_pbus_dx;
    @(posedge core_clk) disable iff (rst)
    variant == FSLE_VAR_PBUS && status.powered && !status.param_error && !status.config_error
      && status.online && status.data_exchange |=> network_indicator.green && !network_indicator.red;
  endproperty
  a_pbus_dx: assert property (p_pbus_dx) else $error("PROFIBUS data exchange not green");

endmodule

// ---- design/fsle_pkg.sv ----
package fsle_pkg;

  // Clock and flash timing
  localparam int         FSLE_CLK_HZ        = 100_000_000;
  localparam int         FSLE_FLASH_HALF_MS = 500;
  localparam int         FSLE_TICK_CYCLES   = FSLE_CLK_HZ / 1000 * FSLE_FLASH_HALF_MS;
  localparam logic [3:0] FSLE_PAUSE_STEPS   = 4'h4;

  // Reset values
  localparam logic [3:0] FSLE_STEP_RST  = 4'h0;
  localparam logic       FSLE_PHASE_RST = 1'b0;

  // Ethernet port configuration driven to the PHY
  localparam logic FSLE_PHY_SPEED_100M = 1'b1;
  localparam logic FSLE_PHY_FULL_DUP   = 1'b1;
  localparam logic FSLE_PHY_AUTO_MDIX  = 1'b1;
  localparam logic FSLE_PHY_AUTO_POL   = 1'b1;

  // Flash counts of the counted red codes
  localparam logic [2:0] FSLE_CNT_IDENT    = 3'h1;
  localparam logic [2:0] FSLE_CNT_NO_IP    = 3'h2;
  localparam logic [2:0] FSLE_CNT_NO_NAME  = 3'h3;
  localparam logic [2:0] FSLE_CNT_MAJOR    = 3'h4;
  localparam logic [2:0] FSLE_CNT_PARAM    = 3'h1;
  localparam logic [2:0] FSLE_CNT_CONFIG   = 3'h2;
  localparam logic [2:0] FSLE_CNT_NONE     = 3'h0;

  typedef enum logic [1:0] {
    FSLE_VAR_IODEV,
    FSLE_VAR_ENIP,
    FSLE_VAR_DNET,
    FSLE_VAR_PBUS
  } fsle_variant_e;

  typedef enum logic [2:0] {
    FSLE_PAT_OFF,
    FSLE_PAT_GREEN,
    FSLE_PAT_RED,
    FSLE_PAT_FLASH_GREEN,
    FSLE_PAT_FLASH_RED,
    FSLE_PAT_ALT,
    FSLE_PAT_COUNT_RED
  } fsle_pat_e;

  typedef struct packed {
    fsle_pat_e  pat;
    logic [2:0] count;
  } fsle_pat_s;

  typedef struct packed {
    logic green;
    logic red;
  } fsle_led_s;

  typedef struct packed {
    logic speed_100m;
    logic full_duplex;
    logic auto_mdix;
    logic auto_polarity;
  } fsle_phy_s;

  typedef struct packed {
    logic powered;
    logic ctrl_connected;
    logic ctrl_run;
    logic setup_state;
    logic network_init_state;
    logic exception;
    logic ident_mismatch;
    logic ip_set;
    logic station_name_set;
    logic major_internal;
    logic diag_present;
    logic identify_req;
    logic link_up;
    logic link_activity;
    logic conn_established;
    logic online;
    logic dup_ip;
    logic fatal_error;
    logic conn_timeout;
    logic scanner_run;
    logic scanner_idle;
    logic configured;
    logic major_fault;
    logic recov_fault;
    logic self_test;
    logic critical_link;
    logic initialised;
    logic data_exchange;
    logic clear_state;
    logic param_error;
    logic config_error;
  } fsle_status_s;

endpackage

// ---- design/fsle_tick.sv ----
`timescale 1ns/1ns
module fsle_tick
  import fsle_pkg::*;
#(
  parameter int CYCLES = FSLE_TICK_CYCLES
)
(
  input  wire logic core_clk,
  input  wire logic rst,
  output logic      tick
);

  localparam int         W    = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);
  localparam logic [W-1:0] ZERO = '0;

  logic [W-1:0] count_r;
  wire          wrap_w = (count_r == LAST);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      count_r <= ZERO;
      tick    <= 1'b0;
    end
    else
    begin
      count_r <= wrap_w ? ZERO : count_r + 1'b1;
      tick    <= wrap_w;
    end
  end

  property p_tick_single;
    @(posedge core_clk) disable iff (rst)
    tick && (CYCLES > 1) |=> !tick;
  endproperty
  a_tick_single: assert property (p_tick_single) else $error("tick longer than one cycle");

endmodule

// ---- design/fsle_led_drv.sv ----
`timescale 1ns/1ns
module fsle_led_drv
  import fsle_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic tick,
  input  fsle_pat_s pattern,
  output fsle_led_s led
);

  logic       phase_r;
  logic [3:0] step_r;
  fsle_pat_s  pat_r;

  wire [3:0] flashes2_w  = {pattern.count, 1'b0};
  wire [3:0] last_step_w = flashes2_w + FSLE_PAUSE_STEPS - 4'h1;
  wire       changed_w   = (pattern != pat_r);
  wire       cnt_on_w    = (step_r < flashes2_w) && !step_r[0];
  wire       is_green_w  = (pattern.pat == FSLE_PAT_GREEN);
  wire       is_red_w    = (pattern.pat == FSLE_PAT_RED);
  wire       is_fgreen_w = (pattern.pat == FSLE_PAT_FLASH_GREEN);
  wire       is_fred_w   = (pattern.pat == FSLE_PAT_FLASH_RED);
  wire       is_alt_w    = (pattern.pat == FSLE_PAT_ALT);
  wire       is_count_w  = (pattern.pat == FSLE_PAT_COUNT_RED);

  // A new pattern restarts the flash sequence at phase 0 and step 0: flashes start dark, counted and alternating patterns start red
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      phase_r <= FSLE_PHASE_RST;
      step_r  <= FSLE_STEP_RST;
      pat_r   <= '0;
    end
    else
    begin
      pat_r <= pattern;
      if (changed_w)
      begin
        phase_r <= FSLE_PHASE_RST;
        step_r  <= FSLE_STEP_RST;
      end
      else if (tick)
      begin
        phase_r <= ~phase_r;
        step_r  <= (step_r >= last_step_w) ? FSLE_STEP_RST : step_r + 4'h1;
      end
    end
  end

  assign led.green = is_green_w | (is_fgreen_w & phase_r) | (is_alt_w & phase_r);
  assign led.red   = is_red_w | (is_fred_w & phase_r) | (is_alt_w & !phase_r) | (is_count_w & cnt_on_w);

  property p_count_pause;
    @(posedge core_clk) disable iff (rst)
    is_count_w && !changed_w && (step_r >= flashes2_w) |-> !led.red && !led.green;
  endproperty
  a_count_pause: assert property (p_count_pause) else $error("LED lit during counted pause");

  property p_alt_exclusive;
    @(posedge core_clk) disable iff (rst)
    is_alt_w |-> (led.red != led.green);
  endproperty
  a_alt_exclusive: assert property (p_alt_exclusive) else $error("alternating pattern not exclusive");

  property p_phase_on_tick;
    @(posedge core_clk) disable iff (rst)
    !tick && !changed_w |=> $stable(phase_r);
  endproperty
  a_phase_on_tick: assert property (p_phase_on_tick) else $error("flash phase moved without tick");

endmodule

// ---- verif/fsle_led_viewer.sv ----
`timescale 1ns/1ns
// Operator's eye on one bicolour LED: counts lit cycles, red onsets and the longest red-dark run
module fsle_led_viewer
  import fsle_pkg::*;
(
  input  wire logic  core_clk,
  input  wire logic  clr,
  input  fsle_led_s  led,
  output logic [15:0] g_cnt_r,
  output logic [15:0] r_cnt_r,
  output logic [15:0] rise_cnt_r,
  output logic [15:0] max_dark_r
);
  logic        red_d_r;
  logic [15:0] run_r;

  always_ff @(posedge core_clk)
  begin
    red_d_r <= led.red;
    if (clr)
    begin
      g_cnt_r    <= 16'h0000;
      r_cnt_r    <= 16'h0000;
      rise_cnt_r <= 16'h0000;
      max_dark_r <= 16'h0000;
      run_r      <= 16'h0000;
    end
    else
    begin
      g_cnt_r    <= g_cnt_r + 16'(led.green);
      r_cnt_r    <= r_cnt_r + 16'(led.red);
      rise_cnt_r <= rise_cnt_r + 16'(led.red & ~red_d_r);
      run_r      <= led.red ? 16'h0000 : run_r + 16'h0001;
      if (!led.red && (run_r + 16'h0001) > max_dark_r)
        max_dark_r <= run_r + 16'h0001;
    end
  end
endmodule

// ---- verif/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
  import fsle_pkg::*;
  localparam int TICK = 4;
  localparam int S    = 32;
  localparam int F    = 16;

  logic          core_clk;
  logic          rst;
  logic          clr;
  fsle_variant_e variant;
  fsle_status_s  status;
  fsle_led_s     net_led;
  fsle_led_s     mod_led;
  fsle_led_s     lnk_led;
  fsle_phy_s     phy_cfg;
  logic [15:0]   g[3];
  logic [15:0]   r[3];
  logic [15:0]   rise[3];
  logic [15:0]   dark[3];
  int            bad_count;
  int            n_checks;

  fsle_encoder #(.TICK_CYCLES(TICK)) u_fsle_encoder (
    .core_clk          (core_clk),
    .rst               (rst),
    .variant           (variant),
    .status            (status),
    .network_indicator (net_led),
    .module_indicator  (mod_led),
    .link_indicator    (lnk_led),
    .phy_cfg           (phy_cfg)
  );

  fsle_led_viewer u_view_net (.core_clk(core_clk), .clr(clr), .led(net_led), .g_cnt_r(g[0]), .r_cnt_r(r[0]),
                              .rise_cnt_r(rise[0]), .max_dark_r(dark[0]));
  fsle_led_viewer u_view_mod (.core_clk(core_clk), .clr(clr), .led(mod_led), .g_cnt_r(g[1]), .r_cnt_r(r[1]),
                              .rise_cnt_r(rise[1]), .max_dark_r(dark[1]));
  fsle_led_viewer u_view_lnk (.core_clk(core_clk), .clr(clr), .led(lnk_led), .g_cnt_r(g[2]), .r_cnt_r(r[2]),
                              .rise_cnt_r(rise[2]), .max_dark_r(dark[2]));

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic apply(input fsle_variant_e v, input fsle_status_s s);
    @(negedge core_clk);
    variant = v;
    status  = s;
  endtask

  task automatic measure(input int len);
    @(negedge core_clk);
    clr = 1'b1;
    @(negedge core_clk);
    clr = 1'b0;
    repeat (len) @(negedge core_clk);
  endtask

  // Lit-cycle counts over a 32-cycle window for the network, module and link LEDs
  task automatic look(input string nm, input int ng, input int nr, input int mg, input int mr,
                      input int lg, input int lr);
    repeat (8) @(negedge core_clk);
    measure(S);
    chk({nm, " net green"}, g[0], 16'(ng));
    chk({nm, " net red"}, r[0], 16'(nr));
    chk({nm, " mod green"}, g[1], 16'(mg));
    chk({nm, " mod red"}, r[1], 16'(mr));
    chk({nm, " link green"}, g[2], 16'(lg));
    chk({nm, " link red"}, r[2], 16'(lr));
  endtask

  // Counted red code: n onsets per group, pause of one dark step plus four pause steps
  task automatic count_code(input string nm, input int sel, input int n);
    int p;
    p = (2 * n + 4) * TICK;
    repeat (p + 8) @(negedge core_clk);
    measure(2 * p);
    chk({nm, " onsets"}, rise[sel], 16'(2 * n));
    chk({nm, " pause"}, dark[sel], 16'((1 + int'(FSLE_PAUSE_STEPS)) * TICK));
    chk({nm, " green"}, g[sel], 16'h0000);
  endtask

  task automatic t_phy;
    chk("phy_cfg", 16'(phy_cfg), 16'({FSLE_PHY_SPEED_100M, FSLE_PHY_FULL_DUP, FSLE_PHY_AUTO_MDIX,
                                     FSLE_PHY_AUTO_POL}));
  endtask

  task automatic t_iodev;
    fsle_status_s s;
    s = '0;
    apply(FSLE_VAR_IODEV, s);
    look("io unpowered", 0, 0, 0, 0, 0, 0);
    s.powered = 1'b1;
    s.setup_state = 1'b1;
    s.ip_set = 1'b1;
    s.station_name_set = 1'b1;
    apply(FSLE_VAR_IODEV, s);
    look("io setup", 0, 0, 0, 0, 0, 0);
    s.setup_state = 1'b0;
    s.network_init_state = 1'b1;
    apply(FSLE_VAR_IODEV, s);
    look("io netinit", 0, 0, 0, 0, 0, 0);
    s.network_init_state = 1'b0;
    s.ctrl_connected = 1'b1;
    s.ctrl_run = 1'b1;
    s.link_up = 1'b1;
    apply(FSLE_VAR_IODEV, s);
    look("io run", S, 0, S, 0, S, 0);
    s.ctrl_run = 1'b0;
    s.link_activity = 1'b1;
    s.diag_present = 1'b1;
    apply(FSLE_VAR_IODEV, s);
    look("io stop", F, 0, F, 0, F, 0);
    s.diag_present = 1'b0;
    s.identify_req = 1'b1;
    s.exception = 1'b1;
    apply(FSLE_VAR_IODEV, s);
    look("io exception", F, 0, 0, S, F, 0);
    s.exception = 1'b0;
    apply(FSLE_VAR_IODEV, s);
    look("io identify", F, 0, F, 0, F, 0);
  endtask

  task automatic t_iodev_codes;
    fsle_status_s s;
    for (int n = 1; n <= 4; n++)
    begin
      s = '0;
      s.powered = 1'b1;
      s.ip_set = (n != 2);
      s.station_name_set = (n != 3);
      s.ident_mismatch = (n == 1);
      s.major_internal = (n == 4);
      apply(FSLE_VAR_IODEV, s);
      count_code($sformatf("io code %0d", n), 1, n);
    end
  endtask

  task automatic t_enip;
    fsle_status_s s;
    s = '0;
    s.powered = 1'b1;
    apply(FSLE_VAR_ENIP, s);
    look("enip no ip", 0, 0, F, 0, 0, 0);
    s.ip_set = 1'b1;
    s.online = 1'b1;
    s.link_up = 1'b1;
    apply(FSLE_VAR_ENIP, s);
    look("enip online", F, 0, F, 0, S, 0);
    s.conn_established = 1'b1;
    s.configured = 1'b1;
    s.scanner_run = 1'b1;
    s.link_activity = 1'b1;
    apply(FSLE_VAR_ENIP, s);
    look("enip run", S, 0, S, 0, F, 0);
    s.scanner_run = 1'b0;
    s.scanner_idle = 1'b1;
    s.conn_timeout = 1'b1;
    apply(FSLE_VAR_ENIP, s);
    look("enip idle", 0, F, F, 0, F, 0);
    s.dup_ip = 1'b1;
    s.recov_fault = 1'b1;
    apply(FSLE_VAR_ENIP, s);
    look("enip dup", 0, S, 0, F, F, 0);
    s.major_fault = 1'b1;
    apply(FSLE_VAR_ENIP, s);
    look("enip major", 0, S, 0, S, F, 0);
  endtask

  task automatic t_dnet;
    fsle_status_s s;
    s = '0;
    s.powered = 1'b1;
    s.link_up = 1'b1;
    apply(FSLE_VAR_DNET, s);
    look("dnet offline", 0, 0, 0, 0, 0, 0);
    s.online = 1'b1;
    s.initialised = 1'b1;
    apply(FSLE_VAR_DNET, s);
    look("dnet noconn", F, 0, F, 0, 0, 0);
    s.conn_established = 1'b1;
    s.configured = 1'b1;
    apply(FSLE_VAR_DNET, s);
    look("dnet conn", S, 0, S, 0, 0, 0);
    s.conn_timeout = 1'b1;
    s.recov_fault = 1'b1;
    apply(FSLE_VAR_DNET, s);
    look("dnet timeout", 0, F, 0, F, 0, 0);
    s.critical_link = 1'b1;
    s.major_fault = 1'b1;
    apply(FSLE_VAR_DNET, s);
    look("dnet fault", 0, S, 0, S, 0, 0);
    s.self_test = 1'b1;
    apply(FSLE_VAR_DNET, s);
    look("dnet selftest", F, F, F, F, 0, 0);
  endtask

  task automatic t_pbus;
    fsle_status_s s;
    s = '0;
    s.powered = 1'b1;
    apply(FSLE_VAR_PBUS, s);
    look("pbus offline", 0, 0, 0, 0, 0, 0);
    s.online = 1'b1;
    s.initialised = 1'b1;
    s.clear_state = 1'b1;
    apply(FSLE_VAR_PBUS, s);
    look("pbus clear", F, 0, S, 0, 0, 0);
    s.clear_state = 1'b0;
    s.data_exchange = 1'b1;
    s.diag_present = 1'b1;
    apply(FSLE_VAR_PBUS, s);
    look("pbus exchange", S, 0, F, 0, 0, 0);
    s.exception = 1'b1;
    s.param_error = 1'b1;
    apply(FSLE_VAR_PBUS, s);
    look("pbus exception", 0, TICK, 0, S, 0, 0);
    count_code("pbus param", 0, 1);
    s.param_error = 1'b0;
    s.config_error = 1'b1;
    apply(FSLE_VAR_PBUS, s);
    count_code("pbus config", 0, 2);
  endtask

  initial
  begin
    bad_count = 0;
    n_checks  = 0;
    rst       = 1'b1;
    clr       = 1'b1;
    variant   = FSLE_VAR_IODEV;
    status    = '0;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    repeat (2) @(negedge core_clk);
    t_phy();
    t_iodev();
    t_iodev_codes();
    t_enip();
    t_dnet();
    t_pbus();
    stop_test();
  end

  // Whole sequence needs about 1700 cycles
  initial
  begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    stop_test();
  end
endmodule
